// file: core/gpmp_regs.svh
`ifndef GPMP_REGS_SVH
`define GPMP_REGS_SVH

// register byte offsets within one port window
`define GPMP_DATA_LO 12'h000
`define GPMP_DATA_HI 12'h3fc
`define GPMP_DIR 12'h400
`define GPMP_SENSE 12'h404
`define GPMP_BOTH 12'h408
`define GPMP_POL 12'h40c
`define GPMP_MASK 12'h410
`define GPMP_RAW 12'h414
`define GPMP_MIS 12'h418
`define GPMP_CLR 12'h41c
`define GPMP_AFSEL 12'h420
`define GPMP_DR2 12'h500
`define GPMP_DR4 12'h504
`define GPMP_DR8 12'h508
`define GPMP_ODR 12'h50c
`define GPMP_PUR 12'h510
`define GPMP_PDR 12'h514
`define GPMP_SLR 12'h518
`define GPMP_DEN 12'h51c
`define GPMP_ID_BASE 12'hfd0

// data mask position within the address
`define GPMP_MASK_LSB 2
`define GPMP_MASK_MSB 9

// reset values of pad controls
`define GPMP_RST_ZERO 8'h00
`define GPMP_RST_ONES 8'hff

// axi response codes
`define GPMP_RESP_OKAY 2'b00
`define GPMP_RESP_SLVERR 2'b10

`endif

// file: core/gpmp_pkg.sv
package gpmp_pkg;
	// pad settings per pin, handed to the pad ring
	typedef struct packed {
		logic [7:0] dig_en;
		logic [7:0] open_drain;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
		logic [7:0] drv_2ma;
		logic [7:0] drv_4ma;
		logic [7:0] drv_8ma;
		logic [7:0] slew;
	} gpmp_pad_t;

	// pin drive from the port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} gpmp_pin_drv_t;
endpackage : gpmp_pkg

// file: core/gpmp_port.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "gpmp_regs.svh"

module gpmp_port
	import gpmp_pkg::*;
#(
	parameter logic [7:0] AFSEL_RESET = 8'h00, // set per instance by the integrator
	parameter logic [7:0] PIN_PRESENT = 8'hff,
	parameter bit IS_TRIGGER_PORT = 1'b0,
	parameter int TRIGGER_PIN = 4,
	parameter logic [31:0] ID_WORD = 32'h0000_00a5 // arbitrary identification value
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and peripheral
	input wire logic [7:0] pin_in,
	output gpmp_pin_drv_t pin_drv,
	output gpmp_pad_t pad_cfg,
	input wire logic [7:0] periph_out,
	input wire logic [7:0] periph_oe,
	output logic [7:0] periph_in,
	// events
	output logic port_irq,
	output logic converter_trigger
);

	// block overview
	// one port of eight pins; the integrator builds five of these side by side
	// every register is one byte wide and sits in byte lane 0 of the bus word
	// upper read bits always return zero, writes to them are dropped
	// the bus side and the pin side share this one clock
	// pins are asynchronous, so they pass two flops before any logic looks at them
	// interrupt logic only ever sees the second synchroniser stage and the third flop behind it
	// the data register is reached through a window of 256 words
	// address bits 9..2 of that window act as a per-bit mask
	// all other registers are plain byte registers at fixed offsets
	// the identification window is read-only and answers from a parameter
	// offsets outside every window answer with a slave error and change nothing

	// configuration registers, edge latch and pin synchroniser flops
	logic [7:0] data_ff, dir_ff, sense_ff, both_ff, pol_ff, mask_ff, afsel_ff;
	logic [7:0] dr2_ff, dr4_ff, dr8_ff, odr_ff, pur_ff, pdr_ff, slr_ff, den_ff;
	logic [7:0] edge_lat_ff;
	logic [7:0] sync1_ff, sync2_ff, prev_ff;

	// axi write and read channel holding
	logic [11:0] awaddr_ff;
	logic aw_have_ff, w_have_ff, bvalid_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff, bresp_ff;

	// synchroniser notes
	// a pin change is visible in the second stage two edges later
	// the third flop keeps the previous settled level for edge detection
	// nothing but the second stage reads the first, to keep metastability contained
	// reset clears all three so no false edge follows reset on a low pin
	// a pin held high through reset shows one rising edge after release;
	// software is expected to clear latched edges before unmasking

	// pin synchroniser, first stage read only by second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= `GPMP_RST_ZERO;
			sync2_ff <= `GPMP_RST_ZERO;
			prev_ff <= `GPMP_RST_ZERO;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// write path notes
	// address and data are held separately and may arrive in either order
	// once both are held the write happens on the following edge
	// the response is raised on that same edge and stands until bready
	// both readies stay low while a response is pending, so one write at a time
	// only byte lane 0 matters; a write with lane 0 disabled changes nothing
	// decoding works on the held address so the bus may move on meanwhile

	// write acceptance: address and data in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	wire wr_go = aw_have_ff && w_have_ff;
	wire [11:0] wa = {awaddr_ff[11:2], 2'b00};
	wire [7:0] wbyte = wstrb_ff[0] ? wdata_ff[7:0] : 8'h00;
	wire wb_en = wstrb_ff[0];
	wire wr_data = wr_go && wb_en && (wa <= `GPMP_DATA_HI);
	wire [7:0] wmask = awaddr_ff[`GPMP_MASK_MSB:`GPMP_MASK_LSB];
	wire wr_hit = wr_go && ((wa <= `GPMP_DATA_HI) || (wa >= `GPMP_DIR && wa <= `GPMP_AFSEL)
		|| (wa >= `GPMP_DR2 && wa <= `GPMP_DEN));
	wire wr_cfg = wr_go && wb_en;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			bresp_ff <= `GPMP_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? `GPMP_RESP_OKAY : `GPMP_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// register update notes
	// each configuration byte updates only on a write to its own offset
	// bits of pins that have no pad keep their reset value forever
	// this hides unconnected bits from software without extra read logic
	// the data register takes a separate path because of its address mask

	// per-register write strobes
	function automatic logic [7:0] upd(input logic [7:0] cur, input logic [11:0] off);
		upd = (wr_cfg && wa == off) ? ((cur & ~PIN_PRESENT) | (wbyte & PIN_PRESENT)) : cur;
	endfunction : upd

	// data register notes
	// the stored byte keeps whatever software wrote, whatever the direction
	// an input pin is seen on reads through the synchroniser, not the store
	// switching a pin to output therefore drives the last written value
	// the mask lets two drivers touch different pins without read-modify-write

	// data register: masked write, store keeps written value whatever the direction
	wire [7:0] data_wmask = wr_data ? (wmask & PIN_PRESENT) : 8'h00;
	wire [7:0] nxt_data = (data_wmask & wbyte) | (~data_wmask & data_ff);

	// reset notes
	// reset is synchronous and restores every configuration byte
	// alternate select comes back to the per-instance default,
	// which hands debug pins back to their debug function
	// 2 mA drive, pull-up and digital enable come back set,
	// so a pin without alternate select is a weakly pulled digital input after any reset

	// configuration state; every reset restores defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_ff <= `GPMP_RST_ZERO;
			dir_ff <= `GPMP_RST_ZERO;
			afsel_ff <= AFSEL_RESET;
			sense_ff <= `GPMP_RST_ZERO;
			both_ff <= `GPMP_RST_ZERO;
			pol_ff <= `GPMP_RST_ZERO;
			mask_ff <= `GPMP_RST_ZERO;
			dr2_ff <= `GPMP_RST_ONES;
			dr4_ff <= `GPMP_RST_ZERO;
			dr8_ff <= `GPMP_RST_ZERO;
			odr_ff <= `GPMP_RST_ZERO;
			pur_ff <= `GPMP_RST_ONES;
			pdr_ff <= `GPMP_RST_ZERO;
			slr_ff <= `GPMP_RST_ZERO;
			den_ff <= `GPMP_RST_ONES;
		end else begin
			data_ff <= nxt_data;
			dir_ff <= upd(dir_ff, `GPMP_DIR);
			afsel_ff <= upd(afsel_ff, `GPMP_AFSEL);
			sense_ff <= upd(sense_ff, `GPMP_SENSE);
			both_ff <= upd(both_ff, `GPMP_BOTH);
			pol_ff <= upd(pol_ff, `GPMP_POL);
			mask_ff <= upd(mask_ff, `GPMP_MASK);
			dr2_ff <= upd(dr2_ff, `GPMP_DR2);
			dr4_ff <= upd(dr4_ff, `GPMP_DR4);
			dr8_ff <= upd(dr8_ff, `GPMP_DR8);
			odr_ff <= upd(odr_ff, `GPMP_ODR);
			pur_ff <= upd(pur_ff, `GPMP_PUR);
			pdr_ff <= upd(pdr_ff, `GPMP_PDR);
			slr_ff <= upd(slr_ff, `GPMP_SLR);
			den_ff <= upd(den_ff, `GPMP_DEN);
		end
	end

	// interrupt notes
	// edge mode latches the event until software writes a one to clear it
	// an edge in the same cycle as its clear wins, so no event is lost
	// level mode is not latched: status follows the synchronised pin
	// the latch is held clear while a pin is in level mode
	// changing sense, both-edges or polarity may raise a spurious event,
	// so software masks the pin first
	// raw status ignores the mask, masked status and the port line do not
	// the converter trigger follows one pin's masked status on one port only

	// interrupt detection per pin
	logic [7:0] edge_hit, level_hit, raw_stat, nxt_edge_lat;
	wire [7:0] clr_bits = (wr_cfg && wa == `GPMP_CLR) ? wbyte : 8'h00;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			wire rise = sync2_ff[i] && !prev_ff[i];
			wire fall = !sync2_ff[i] && prev_ff[i];
			assign edge_hit[i] = both_ff[i] ? (rise || fall) : (pol_ff[i] ? rise : fall);
			assign level_hit[i] = pol_ff[i] ? sync2_ff[i] : !sync2_ff[i];
			// edge latch; a new edge wins over a clear
			assign nxt_edge_lat[i] = edge_hit[i] || (edge_lat_ff[i] && !clr_bits[i]);
			assign raw_stat[i] = PIN_PRESENT[i] &&
				(sense_ff[i] ? level_hit[i] : edge_lat_ff[i]);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_lat_ff <= `GPMP_RST_ZERO;
		end else begin
			edge_lat_ff <= nxt_edge_lat & ~sense_ff;
		end
	end

	wire [7:0] mis_stat = raw_stat & mask_ff;
	assign port_irq = |mis_stat;
	assign converter_trigger = IS_TRIGGER_PORT && mis_stat[TRIGGER_PIN];

	// pin control notes
	// alternate select hands both level and enable to the peripheral
	// otherwise the direction byte and the data store drive the pin
	// output enable is gated by digital enable so an analog pin never drives
	// the peripheral sees synchronised levels, zero where digital is off

	// pin control: alternate function or software
	wire [7:0] sw_oe = dir_ff & PIN_PRESENT;
	assign pin_drv.out = (afsel_ff & periph_out) | (~afsel_ff & data_ff);
	assign pin_drv.oe = ((afsel_ff & periph_oe) | (~afsel_ff & sw_oe)) & den_ff;
	assign periph_in = sync2_ff & den_ff;
	assign pad_cfg = '{dig_en: den_ff, open_drain: odr_ff, pull_up: pur_ff, pull_down: pdr_ff,
		drv_2ma: dr2_ff, drv_4ma: dr4_ff, drv_8ma: dr8_ff, slew: slr_ff};

	// read path notes
	// a read is taken whenever no answer is pending and answers one edge later
	// the answer stands until rready; arready stays low meanwhile
	// data reads apply the address mask to the live view of the port
	// the clear register reads as zero, it only acts on writes
	// the identification window repeats the four bytes of the id word

	// read path
	wire ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !rvalid_ff;
	wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
	wire [7:0] rmask = s_axi_araddr[`GPMP_MASK_MSB:`GPMP_MASK_LSB];
	wire [7:0] data_view = ((dir_ff & data_ff) | (~dir_ff & sync2_ff)) & PIN_PRESENT;
	wire [7:0] id_byte = ID_WORD[{ra[3:2], 3'b000} +: 8];
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (ra)
			`GPMP_DIR: rd_byte = dir_ff;
			`GPMP_SENSE: rd_byte = sense_ff;
			`GPMP_BOTH: rd_byte = both_ff;
			`GPMP_POL: rd_byte = pol_ff;
			`GPMP_MASK: rd_byte = mask_ff;
			`GPMP_RAW: rd_byte = raw_stat;
			`GPMP_MIS: rd_byte = mis_stat;
			`GPMP_CLR: rd_byte = 8'h00;
			`GPMP_AFSEL: rd_byte = afsel_ff;
			`GPMP_DR2: rd_byte = dr2_ff;
			`GPMP_DR4: rd_byte = dr4_ff;
			`GPMP_DR8: rd_byte = dr8_ff;
			`GPMP_ODR: rd_byte = odr_ff;
			`GPMP_PUR: rd_byte = pur_ff;
			`GPMP_PDR: rd_byte = pdr_ff;
			`GPMP_SLR: rd_byte = slr_ff;
			`GPMP_DEN: rd_byte = den_ff;
			default: begin
				if (ra <= `GPMP_DATA_HI) begin
					rd_byte = data_view & rmask;
				end else if (ra >= `GPMP_ID_BASE) begin
					rd_byte = id_byte;
				end else begin
					rd_byte = 8'h00;
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `GPMP_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte};
			rresp_ff <= rd_ok ? `GPMP_RESP_OKAY : `GPMP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule : gpmp_port

// file: verification/gpmp_pins.sv
module gpmp_pins
	import gpmp_pkg::*;
(
	// port drive and outside level
	input wire gpmp_pin_drv_t pin_drv,
	input wire logic [7:0] ext_level,
	// level seen by the port
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven bits follow the port, the rest the source, which holds its level
	assign pin_in = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & ext_level);
endmodule : gpmp_pins

// file: verification/gpmp_port_chk.sv
module gpmp_port_chk
	import gpmp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// pins and events
	input wire gpmp_pin_drv_t pin_drv,
	input wire gpmp_pad_t pad_cfg,
	input wire logic port_irq,
	input wire logic converter_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// bus handshake relations
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	busy_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read ready wrong");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	// events and pads
	trig_irq_a: assert property (converter_trigger |-> port_irq)
		else $error("trigger without port interrupt");
	pad_reset_a: assert property ($rose(aresetn) |-> pad_cfg.dig_en == 8'hff && pad_cfg.pull_up == 8'hff
		&& pad_cfg.drv_2ma == 8'hff && pad_cfg.open_drain == 8'h00) else $error("pad reset values wrong");
	oe_den_a: assert property ((pin_drv.oe & ~pad_cfg.dig_en) == 8'h00)
		else $error("pin driven without digital enable");
	// main scenarios
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid);
	cover property ($rose(port_irq));
	cover property (converter_trigger);
endmodule : gpmp_port_chk

bind gpmp_port gpmp_port_chk chk (.*);

// file: verification/tb_gpmp_port.sv
`include "gpmp_regs.svh"
module tb_gpmp_port;
	timeunit 1ns;
	timeprecision 1ps;
	import gpmp_pkg::*;
	localparam logic [1:0] OK = `GPMP_RESP_OKAY;
	localparam logic [1:0] ER = `GPMP_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] ext_level = 8'h0, periph_out = 8'h0, periph_oe = 8'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_irq, converter_trigger;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] pin_in, periph_in;
	gpmp_pin_drv_t pin_drv;
	gpmp_pad_t pad_cfg;
	int n_fail = 0;
	int comparisons = 0;
	// clock and instances
	always #10 aclk = ~aclk;
	gpmp_port #(.IS_TRIGGER_PORT(1'b1), .TRIGGER_PIN(4), .ID_WORD(32'h0000_00c3)) DUT (.*);
	gpmp_pins pins (.pin_drv(pin_drv), .ext_level(ext_level), .pin_in(pin_in));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// write: offer both channels, release each when taken, then accept the response late
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, ta, tw;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(negedge aclk);
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			aw = aw && !ta;
			w = w && !tw;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		@(negedge aclk);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		chk("rdata", {24'h0, e}, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge aclk);
	endtask : rd
	task automatic t_reset;
		rd(`GPMP_DIR, 8'h00, OK);
		rd(`GPMP_AFSEL, 8'h00, OK);
		rd(`GPMP_DEN, 8'hff, OK);
		rd(`GPMP_PUR, 8'hff, OK);
		rd(`GPMP_DR2, 8'hff, OK);
		rd(`GPMP_ID_BASE, 8'hc3, OK);
		rd(12'hfd4, 8'h00, OK);
		$display("test reset done");
	endtask : t_reset
	task automatic t_data;
		wr(`GPMP_DIR, 8'hff, OK);
		wr(12'h3fc, 8'h00, OK);
		wr(12'h098, 8'heb, OK);
		rd(12'h3fc, 8'h22, OK);
		rd(12'h0c4, 8'h20, OK);
		chk("pin_out", 32'h22, {24'h0, pin_drv.out});
		wr(`GPMP_DIR, 8'h0f, OK);
		ext_level <= 8'ha5;
		repeat (3) @(posedge aclk);
		rd(12'h3fc, 8'ha2, OK);
		wr(`GPMP_DIR, 8'h00, OK);
		$display("test data done");
	endtask : t_data
	task automatic t_edge;
		wr(`GPMP_POL, 8'h10, OK);
		wr(`GPMP_MASK, 8'h10, OK);
		wr(`GPMP_CLR, 8'hff, OK);
		ext_level <= 8'hb5;
		repeat (4) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, port_irq});
		chk("trigger", 32'h1, {31'h0, converter_trigger});
		ext_level <= 8'ha5;
		rd(`GPMP_RAW, 8'h10, OK);
		wr(`GPMP_MASK, 8'h00, OK);
		rd(`GPMP_MIS, 8'h00, OK);
		chk("irq", 32'h0, {31'h0, port_irq});
		wr(`GPMP_CLR, 8'h10, OK);
		wr(`GPMP_BOTH, 8'h10, OK);
		ext_level <= 8'hb5;
		repeat (4) @(posedge aclk);
		wr(`GPMP_CLR, 8'h10, OK);
		ext_level <= 8'ha5;
		repeat (4) @(posedge aclk);
		wr(`GPMP_CLR, 8'h00, OK);
		rd(`GPMP_RAW, 8'h10, OK);
		wr(`GPMP_CLR, 8'h10, OK);
		rd(`GPMP_RAW, 8'h00, OK);
		$display("test edge done");
	endtask : t_edge
	task automatic t_level;
		wr(`GPMP_SENSE, 8'h02, OK);
		rd(`GPMP_RAW, 8'h02, OK);
		ext_level <= 8'ha7;
		repeat (3) @(posedge aclk);
		rd(`GPMP_RAW, 8'h00, OK);
		$display("test level done");
	endtask : t_level
	task automatic t_alt;
		wr(`GPMP_AFSEL, 8'hff, OK);
		periph_out <= 8'h5a;
		periph_oe <= 8'hff;
		@(posedge aclk);
		@(negedge aclk);
		chk("pin_drv", 32'h5aff, {16'h0, pin_drv});
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk("periph_in", 32'h5a, {24'h0, periph_in});
		@(posedge aclk);
		periph_oe <= 8'h00;
		rd(12'h600, 8'h00, ER);
		wr(12'h600, 8'h55, ER);
		$display("test alternate and unmapped done");
	endtask : t_alt
	task automatic t_again;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`GPMP_AFSEL, 8'h00, OK);
		rd(`GPMP_SENSE, 8'h00, OK);
		$display("test second reset done");
	endtask : t_again
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// watchdog
	initial begin
		#400us;
		n_fail++;
		results();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		s_axi_rready <= 1'b1;
		t_reset();
		t_data();
		t_edge();
		t_level();
		t_alt();
		t_again();
		results();
	end
endmodule : tb_gpmp_port
